// ---- logic/osf_pin_framing.sv ----
// device-side pin framing for an octal serial flash link
`timescale 1ns/1ps
`default_nettype none
`include "osf_consts.svh"
module osf_pin_framing #(
	parameter int ADDR_BYTES  = `OSF_ADDR_BYTES,
	parameter int DUMMY_BEATS = `OSF_DUMMY_BEATS
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// link pins
	input  wire logic       chip_select_n,
	input  wire logic       link_ck,
	input  wire logic       hardware_reset_n,
	input  wire logic [7:0] dq_in,
	output logic      [7:0] dq_out,
	output logic      [7:0] dq_oe,
	output logic            read_data_strobe,
	output logic            read_data_strobe_oe,
	// configuration and core status, same clock
	input  wire logic       ddr_mode,
	input  wire logic       x1_mode,
	input  wire logic       embedded_busy,
	// received bytes to the core
	output logic      [7:0] rx_byte,
	output logic            rx_valid,
	output logic            rx_first,
	// read data from the core
	input  wire logic [7:0] tx_byte,
	output logic            tx_req,
	// frame status
	output logic            active,
	output logic            standby,
	output logic            frame_start,
	output logic            frame_end,
	output logic            in_reset
);
	logic                     rst_s;
	logic [`OSF_PIN_BITS-1:0] pins_s;
	logic                     cs_s;
	logic                     ck_s;
	logic                     hwrst_s;
	logic [7:0]               dq_s;
	logic                     ck_prev_q;
	logic                     cs_prev_q;
	logic                     ck_rise;
	logic                     ck_fall;
	logic                     cs_fall;
	logic                     cs_rise;
	logic                     sel;
	logic                     dual;
	logic                     sample;
	logic                     launch;
	osf_pkg::phase_t          state_q;
	osf_pkg::phase_t          state_d;
	logic [7:0]               cnt_q;
	logic [7:0]               cnt_d;
	logic [2:0]               bit_q;
	logic [2:0]               bit_d;
	logic [7:0]               shift_q;
	logic [7:0]               shift_d;
	logic [7:0]               word;
	logic [7:0]               dq_out_q;
	logic [7:0]               dq_out_d;
	logic [7:0]               dq_oe_q;
	logic [7:0]               dq_oe_d;
	logic                     strobe_q;
	logic                     strobe_d;
	logic                     strobe_oe_q;
	logic                     strobe_oe_d;
	logic                     tx_req_q;
	logic                     tx_req_d;
	logic [7:0]               rx_byte_q;
	logic [7:0]               rx_byte_d;
	logic                     rx_valid_q;
	logic                     rx_valid_d;
	logic                     rx_first_q;
	logic                     rx_first_d;
	logic [4:0]               stat_q;
	logic [4:0]               stat_d;

	if (ADDR_BYTES < 1 || ADDR_BYTES > `OSF_CNT_MAX)
	begin : g_bad_addr
		$error("ADDR_BYTES out of range");
	end
	if (DUMMY_BEATS < 1 || DUMMY_BEATS > `OSF_CNT_MAX)
	begin : g_bad_dummy
		$error("DUMMY_BEATS out of range");
	end

	// reset release through two flip-flops
	pin_sync #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
		.clk     (clk),
		.rst_n   (rstn),
		.async_i (1'b1),
		.sync_o  (rst_s)
	);

	// every pin crosses in one bank so lanes and clock stay aligned
	pin_sync #(.WIDTH(`OSF_PIN_BITS), .INIT(`OSF_PIN_INIT)) u_pin_sync (
		.clk     (clk),
		.rst_n   (rst_s),
		.async_i ({chip_select_n, link_ck, hardware_reset_n, dq_in}),
		.sync_o  (pins_s)
	);

	assign cs_s    = pins_s[10];
	assign ck_s    = pins_s[9];
	assign hwrst_s = pins_s[8];
	assign dq_s    = pins_s[7:0];

	// edges of the sampled link clock and chip select
	always_ff @(posedge clk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			ck_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end
		else
		begin
			ck_prev_q <= ck_s;
			cs_prev_q <= cs_s;
		end
	end

	assign ck_rise = ck_s & ~ck_prev_q;
	assign ck_fall = ~ck_s & ck_prev_q;
	assign cs_fall = cs_prev_q & ~cs_s;
	assign cs_rise = ~cs_prev_q & cs_s;
	// reset pin overrides selection whatever chip select does
	assign sel     = ~cs_s & hwrst_s;
	// legacy single-bit interface has no double rate
	assign dual    = ddr_mode & ~x1_mode;
	assign sample  = sel & (ck_rise | (dual & ck_fall));
	assign launch  = sel & (dual ? (ck_rise | ck_fall) : ck_fall);

	// input byte packer
	lane_if lanes ();
	assign lanes.beat  = sample & (state_q == osf_pkg::PH_CMD || state_q == osf_pkg::PH_ADDR
		|| state_q == osf_pkg::PH_WDATA);
	assign lanes.x1    = x1_mode;
	assign lanes.clear = (state_q == osf_pkg::PH_IDLE);
	assign lanes.lanes = dq_s;

	byte_packer u_packer (
		.clk   (clk),
		.rst_n (rst_s),
		.p     (lanes)
	);

	// next word to launch: legacy mode reloads only on the byte boundary
	always_comb
	begin
		word = (x1_mode && bit_q != 3'h0) ? shift_q : tx_byte;
	end

	// transaction phase, counters and pin drive
	always_comb
	begin
		state_d     = state_q;
		cnt_d       = cnt_q;
		bit_d       = bit_q;
		shift_d     = shift_q;
		dq_out_d    = dq_out_q;
		dq_oe_d     = dq_oe_q;
		strobe_d    = strobe_q;
		strobe_oe_d = strobe_oe_q;
		tx_req_d    = 1'b0;
		if (!sel)
		begin
			// deselected or in pin reset: idle and let go of every pin
			state_d     = osf_pkg::PH_IDLE;
			cnt_d       = 8'h00;
			bit_d       = 3'h0;
			dq_oe_d     = 8'h00;
			strobe_d    = 1'b0;
			strobe_oe_d = 1'b0;
		end
		else
		begin
			case (state_q)
				osf_pkg::PH_IDLE:
				begin
					// a reset released mid-frame waits for the next falling select
					if (cs_fall)
						state_d = osf_pkg::PH_CMD;
				end
				osf_pkg::PH_CMD:
				begin
					if (lanes.byte_valid)
					begin
						cnt_d   = 8'h00;
						state_d = (lanes.byte_q == `OSF_CMD_READ) ? osf_pkg::PH_ADDR : osf_pkg::PH_WDATA;
					end
				end
				osf_pkg::PH_ADDR:
				begin
					if (lanes.byte_valid)
					begin
						cnt_d = cnt_q + 8'h01;
						if (cnt_q == 8'(ADDR_BYTES - 1))
						begin
							cnt_d   = 8'h00;
							state_d = osf_pkg::PH_DUMMY;
						end
					end
				end
				osf_pkg::PH_DUMMY:
				begin
					// dummy beats count launch edges so data lines up with them
					if (launch)
					begin
						cnt_d = cnt_q + 8'h01;
						if (cnt_q == 8'(DUMMY_BEATS - 1))
						begin
							cnt_d   = 8'h00;
							bit_d   = 3'h0;
							state_d = osf_pkg::PH_RDATA;
						end
					end
				end
				osf_pkg::PH_RDATA:
				begin
					if (launch)
					begin
						tx_req_d    = ~x1_mode | (bit_q == 3'h0);
						strobe_d    = ~strobe_q;
						strobe_oe_d = 1'b1;
						if (x1_mode)
						begin
							dq_out_d                 = 8'h00;
							dq_out_d[`OSF_LEGACY_OUT] = word[7];
							dq_oe_d                  = `OSF_X1_OE;
							shift_d                  = {word[6:0], 1'b0};
							bit_d                    = bit_q + 3'h1;
						end
						else
						begin
							dq_out_d = word;
							dq_oe_d  = 8'hFF;
						end
					end
				end
				osf_pkg::PH_WDATA:
				begin
					state_d = osf_pkg::PH_WDATA;
				end
				default:
				begin
					state_d = osf_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// received bytes and frame status
	always_comb
	begin
		rx_byte_d  = rx_byte_q;
		rx_first_d = rx_first_q;
		rx_valid_d = 1'b0;
		if (sel && lanes.byte_valid && state_q != osf_pkg::PH_IDLE)
		begin
			rx_valid_d = 1'b1;
			rx_byte_d  = lanes.byte_q;
			rx_first_d = (state_q == osf_pkg::PH_CMD);
		end
		stat_d[0] = sel;
		stat_d[1] = cs_s & ~embedded_busy;
		stat_d[2] = cs_fall & hwrst_s;
		stat_d[3] = cs_rise;
		stat_d[4] = ~hwrst_s;
	end

	always_ff @(posedge clk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			state_q     <= osf_pkg::PH_IDLE;
			cnt_q       <= 8'h00;
			bit_q       <= 3'h0;
			shift_q     <= 8'h00;
			dq_out_q    <= 8'h00;
			dq_oe_q     <= 8'h00;
			strobe_q    <= 1'b0;
			strobe_oe_q <= 1'b0;
			tx_req_q    <= 1'b0;
			rx_byte_q   <= 8'h00;
			rx_valid_q  <= 1'b0;
			rx_first_q  <= 1'b0;
			stat_q      <= 5'h02;
		end
		else
		begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			bit_q       <= bit_d;
			shift_q     <= shift_d;
			dq_out_q    <= dq_out_d;
			dq_oe_q     <= dq_oe_d;
			strobe_q    <= strobe_d;
			strobe_oe_q <= strobe_oe_d;
			tx_req_q    <= tx_req_d;
			rx_byte_q   <= rx_byte_d;
			rx_valid_q  <= rx_valid_d;
			rx_first_q  <= rx_first_d;
			stat_q      <= stat_d;
		end
	end

	assign dq_out              = dq_out_q;
	assign dq_oe               = dq_oe_q;
	assign read_data_strobe    = strobe_q;
	assign read_data_strobe_oe = strobe_oe_q;
	assign tx_req              = tx_req_q;
	assign rx_byte             = rx_byte_q;
	assign rx_valid            = rx_valid_q;
	assign rx_first            = rx_first_q;
	assign active              = stat_q[0];
	assign standby             = stat_q[1];
	assign frame_start         = stat_q[2];
	assign frame_end           = stat_q[3];
	assign in_reset            = stat_q[4];

	// checks; configuration inputs are assumed static within a frame
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_s);

	a_start_pulse: assert property (cs_fall && hwrst_s |=> frame_start && state_q == osf_pkg::PH_CMD)
		else $error("frame start not taken");
	a_end_idle: assert property (cs_rise |=> frame_end && state_q == osf_pkg::PH_IDLE)
		else $error("frame end not taken");
	a_active_level: assert property (active == $past(sel))
		else $error("active does not follow selection");
	a_standby_busy: assert property (cs_s && embedded_busy |=> !standby)
		else $error("standby while embedded operation runs");
	a_deselect_hiz: assert property (cs_s |=> dq_oe == 8'h00 && !read_data_strobe_oe)
		else $error("pins driven while deselected");
	a_reset_hiz: assert property (!hwrst_s |=> dq_oe == 8'h00 && !read_data_strobe_oe && state_q == osf_pkg::PH_IDLE)
		else $error("pins driven during pin reset");
	a_sdr_sample: assert property (!dual && ck_fall |-> !lanes.beat)
		else $error("single rate sampled on falling edge");
	a_ddr_sample: assert property (dual && sel && ck_fall && state_q == osf_pkg::PH_CMD |-> lanes.beat)
		else $error("double rate missed falling edge");
	a_sdr_launch: assert property (sel && !dual && ck_rise && state_q == osf_pkg::PH_RDATA |=> $stable(dq_out) && $stable(read_data_strobe))
		else $error("single rate launched on rising edge");
	a_strobe_toggle: assert property (launch && state_q == osf_pkg::PH_RDATA |=> $changed(read_data_strobe) && read_data_strobe_oe)
		else $error("strobe did not toggle with data");
	a_strobe_read: assert property (read_data_strobe_oe |-> state_q == osf_pkg::PH_RDATA)
		else $error("strobe driven outside read data");
	a_no_drive_cmd: assert property (state_q != osf_pkg::PH_RDATA |-> dq_oe == 8'h00)
		else $error("lines driven outside read data");
	a_legacy_lane: assert property (x1_mode && dq_oe != 8'h00 |-> dq_oe == `OSF_X1_OE)
		else $error("legacy mode drives wrong line");

	c_read_frame: cover property (state_q == osf_pkg::PH_RDATA && cs_rise);
	c_write_frame: cover property (state_q == osf_pkg::PH_WDATA && rx_valid);
	c_ddr_read: cover property (dual && launch && state_q == osf_pkg::PH_RDATA);
	c_reset_frame: cover property (!cs_s && !hwrst_s && $past(state_q) != osf_pkg::PH_IDLE);
endmodule : osf_pin_framing
`default_nettype wire

// ---- logic/osf_consts.svh ----
// constants for the octal serial pin framing block
`ifndef OSF_CONSTS_SVH
`define OSF_CONSTS_SVH

`define OSF_CMD_READ      8'h03
`define OSF_ADDR_BYTES    4
`define OSF_DUMMY_BEATS   8
`define OSF_LANES         8
`define OSF_LEGACY_IN     0
`define OSF_LEGACY_OUT    1
`define OSF_X1_OE         8'h02
`define OSF_X1_LAST_BIT   3'h7
`define OSF_PIN_BITS      11
`define OSF_PIN_INIT      11'h500
`define OSF_CNT_MAX       255

`endif

// ---- logic/osf_pkg.sv ----
// types shared by the octal serial pin framing modules
package osf_pkg;
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_CMD,
		PH_ADDR,
		PH_DUMMY,
		PH_RDATA,
		PH_WDATA
	} phase_t;
endpackage : osf_pkg

// ---- logic/lane_if.sv ----
// interface between the framing core and its input byte packer
`timescale 1ns/1ps
`default_nettype none
interface lane_if;
	logic       beat;
	logic       x1;
	logic       clear;
	logic [7:0] lanes;
	logic [7:0] byte_q;
	logic       byte_valid;
	modport owner  (output beat, x1, clear, lanes, input byte_q, byte_valid);
	modport packer (input beat, x1, clear, lanes, output byte_q, byte_valid);
endinterface : lane_if
`default_nettype wire

// ---- logic/pin_sync.sv ----
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// raw pins and their synchronised copy
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("pin_sync width must be at least one");
	end

	// first stage feeds only the second
	always_comb
	begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= INIT;
			sync_q <= INIT;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule : pin_sync
`default_nettype wire

// ---- logic/byte_packer.sv ----
// gathers sampled lane values into bytes, octal or legacy single bit
`timescale 1ns/1ps
`default_nettype none
`include "osf_consts.svh"
module byte_packer (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// lane beats in, bytes out
	lane_if.packer   p
);
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic [7:0] byte_q;
	logic [7:0] byte_d;
	logic       valid_q;
	logic       valid_d;

	// legacy mode takes the input line msb first, eight beats a byte
	always_comb
	begin
		shift_d = shift_q;
		cnt_d   = cnt_q;
		byte_d  = byte_q;
		valid_d = 1'b0;
		if (p.clear)
		begin
			shift_d = 8'h00;
			cnt_d   = 3'h0;
		end
		else if (p.beat)
		begin
			if (p.x1)
			begin
				shift_d = {shift_q[6:0], p.lanes[`OSF_LEGACY_IN]};
				cnt_d   = cnt_q + 3'h1;
				if (cnt_q == `OSF_X1_LAST_BIT)
				begin
					byte_d  = shift_d;
					valid_d = 1'b1;
				end
			end
			else
			begin
				byte_d  = p.lanes;
				valid_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_q <= 8'h00;
			cnt_q   <= 3'h0;
			byte_q  <= 8'h00;
			valid_q <= 1'b0;
		end
		else
		begin
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
			byte_q  <= byte_d;
			valid_q <= valid_d;
		end
	end

	assign p.byte_q     = byte_q;
	assign p.byte_valid = valid_q;
endmodule : byte_packer
`default_nettype wire

// ---- testbench/host_model.sv ----
// host controller model: drives chip select, link clock and data lines
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// link pins towards the device
	output var logic       cs_n,
	output var logic       ck,
	output wire logic [7:0] dq_in,
	// device drive and mode
	input  wire logic [7:0] dq_out,
	input  wire logic [7:0] dq_oe,
	input  wire logic       strobe,
	input  wire logic       strobe_oe,
	input  wire logic       x1
);
	logic [7:0] hq;
	logic       hen;
	logic [7:0] sh;
	int         nb;
	int         clash;
	logic [7:0] got[$];

	// released lines show the inverse of the last value, so a stale copy never passes
	assign dq_in = (dq_oe & dq_out) | (~dq_oe & (hen ? hq : ~hq));

	initial
	begin
		cs_n = 1'b1;
		ck = 1'b0;
		hq = 8'h00;
		hen = 1'b0;
		nb = 0;
		clash = 0;
	end

	// both parties driving the lines at once
	always @(dq_oe or hen)
		if (hen && dq_oe !== 8'h00)
			clash++;

	// capture on strobe edges, not on the link clock
	always @(strobe)
	begin
		#1;
		if (strobe_oe === 1'b1)
		begin
			if (x1)
			begin
				sh = {sh[6:0], dq_in[1]};
				nb++;
				if (nb == 8)
				begin
					got.push_back(sh);
					nb = 0;
				end
			end
			else
				got.push_back(dq_in);
		end
	end

	task automatic start();
		#13 cs_n = 1'b0;
		#80;
	endtask : start

	// deselect first: a parking edge while selected would be one launch too many
	task automatic stop();
		#80 hen = 1'b0;
		cs_n = 1'b1;
		if (ck)
			#40 ck = 1'b0;
		#160;
	endtask : stop

	// one byte: octal on all lines, legacy msb first on line 0
	task automatic put(input logic [7:0] b, input bit ddr, input bit one);
		int i;
		hen = 1'b1;
		for (i = 7; i >= 0; i--)
		begin
			hq = one ? {hq[7:1], b[i]} : b;
			if (ddr)
			begin
				#40 ck = ~ck;
				#40;
			end
			else
			begin
				#40 ck = 1'b1;
				#80 ck = 1'b0;
				#40;
			end
			if (!one)
				break;
		end
	endtask : put

	// free edges for dummy and read beats, lines released
	task automatic clocks(input int n);
		hen = 1'b0;
		repeat (n)
			#80 ck = ~ck;
	endtask : clocks
endmodule : host_model
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the octal serial pin framing block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, rstn, hardware_reset_n, ddr_mode, x1_mode, embedded_busy;
	logic  [7:0] tx_byte, dq_in, dq_out, dq_oe, rx_byte;
	logic        chip_select_n, link_ck, read_data_strobe, read_data_strobe_oe;
	logic        rx_valid, rx_first, tx_req, active, standby, frame_start, frame_end, in_reset;
	logic [15:0] seed, e;
	logic  [8:0] exp_rx[$];
	logic  [7:0] exp_tx[$];
	int          bad_count, n_tests, nf, fs, fe;

	osf_pin_framing uut (
		.clk, .rstn, .chip_select_n, .link_ck, .hardware_reset_n, .dq_in, .dq_out, .dq_oe,
		.read_data_strobe, .read_data_strobe_oe, .ddr_mode, .x1_mode, .embedded_busy,
		.rx_byte, .rx_valid, .rx_first, .tx_byte, .tx_req, .active, .standby,
		.frame_start, .frame_end, .in_reset
	);

	host_model hm (
		.cs_n(chip_select_n), .ck(link_ck), .dq_in, .dq_out, .dq_oe,
		.strobe(read_data_strobe), .strobe_oe(read_data_strobe_oe), .x1(x1_mode)
	);

	always #10 clk = ~clk;

	function automatic logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction : rnd

	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
		n_tests++;
		if (g !== ex)
		begin
			bad_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, ex, g);
		end
	endtask : chk

	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	// reference model: expected received bytes, taken read bytes, frame counts
	always @(posedge clk)
	begin
		if (frame_start === 1'b1)
			fs++;
		if (frame_end === 1'b1)
			fe++;
		if (tx_req === 1'b1)
		begin
			exp_tx.push_back(tx_byte);
			tx_byte <= #2 rnd();
		end
		if (rx_valid === 1'b1)
		begin
			e = exp_rx.size() ? {7'h00, exp_rx.pop_front()} : 16'hFFFF;
			chk("rx_byte", e, {7'h00, rx_first, rx_byte});
		end
	end

	task automatic send(input logic [7:0] b, input bit f);
		exp_rx.push_back({f, b});
		hm.put(b, ddr_mode, x1_mode);
	endtask : send

	// one frame; reads get enough edges for n bytes beyond the dummy beats
	task automatic frame(input bit rd, input bit ddr, input bit x1, input int n, input bit hr);
		logic [7:0] c;
		int         i;
		exp_tx.delete();
		hm.got.delete();
		hm.nb = 0;
		@(posedge clk);
		#2 ddr_mode = ddr;
		x1_mode = x1;
		c = rd ? 8'h03 : rnd();
		if (!rd && c == 8'h03)
			c = 8'h04;
		hm.start();
		send(c, 1'b1);
		for (i = 0; i < (rd ? 4 : n); i++)
			send(rnd(), 1'b0);
		chk("selected", 16'h0002, {active, standby});
		chk("lines_free", 16'h0000, {dq_oe, read_data_strobe_oe});
		if (rd)
		begin
			// single rate: the fall closing the last address beat is already dummy edge one
			hm.clocks(x1 ? 16 * (1 + n) - 2 : (ddr ? 8 + n : 2 * (7 + n)));
			#100;
		end
		if (rd && hr)
		begin
			@(posedge clk);
			#2 hardware_reset_n = 1'b0;
			repeat (4) @(posedge clk);
			#2 chk("reset_mid_read", 16'h0200, {in_reset, dq_oe, read_data_strobe_oe});
			hardware_reset_n = 1'b1;
		end
		else if (rd)
			chk("drive", {x1 ? 8'h02 : 8'hFF, 1'b1}, {dq_oe, read_data_strobe_oe});
		hm.stop();
		nf++;
		chk("standby_idle", 16'h0200, {active, standby, dq_oe, read_data_strobe_oe});
		chk("frames", {nf[7:0], nf[7:0]}, {fs[7:0], fe[7:0]});
		chk("rx_left", 16'h0000, 16'(exp_rx.size()));
		if (rd && !hr)
		begin
			chk("read_count", 16'(exp_tx.size()), 16'(hm.got.size()));
			chk("read_len", 16'(n), 16'(hm.got.size()));
			for (i = 0; i < hm.got.size() && i < exp_tx.size(); i++)
				chk("read_byte", exp_tx[i], hm.got[i]);
		end
	endtask : frame

	// watchdog: the whole sequence needs well under a fifth of this
	initial
	begin
		#1000000;
		bad_count++;
		results();
	end

	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		hardware_reset_n = 1'b1;
		ddr_mode = 1'b0;
		x1_mode = 1'b0;
		embedded_busy = 1'b0;
		bad_count = 0;
		n_tests = 0;
		nf = 0;
		fs = 0;
		fe = 0;
		seed = 16'h6D62;
		tx_byte = rnd();
		repeat (20) @(posedge clk);
		#2 rstn = 1'b1;
		repeat (6) @(posedge clk);
		#2 chk("after_reset", 16'h0200, {active, standby, dq_oe, read_data_strobe_oe});
		// single, double and legacy rates, writes then reads
		frame(1'b0, 1'b0, 1'b0, 3, 1'b0);
		frame(1'b1, 1'b0, 1'b0, 4, 1'b0);
		frame(1'b0, 1'b1, 1'b0, 5, 1'b0);
		frame(1'b1, 1'b1, 1'b0, 6, 1'b0);
		frame(1'b0, 1'b0, 1'b1, 2, 1'b0);
		frame(1'b1, 1'b0, 1'b1, 2, 1'b0);
		frame(1'b1, 1'b0, 1'b0, 3, 1'b1);
		frame(1'b1, 1'b1, 0, 1, 1'b0);
		// clock and data while deselected must be ignored
		hm.put(rnd(), 1'b0, 1'b0);
		hm.put(rnd(), 1'b0, 1'b0);
		#200 chk("deselected", {nf[7:0], nf[7:0]}, {fs[7:0], fe[7:0]});
		@(posedge clk);
		#2 embedded_busy = 1'b1;
		repeat (3) @(posedge clk);
		#2 chk("busy_standby", 16'h0000, standby);
		embedded_busy = 1'b0;
		repeat (3) @(posedge clk);
		#2 chk("standby", 16'h0001, standby);
		hardware_reset_n = 1'b0;
		repeat (4) @(posedge clk);
		#2 chk("reset_pin", 16'h0001, in_reset);
		hardware_reset_n = 1'b1;
		repeat (4) @(posedge clk);
		#2 chk("reset_pin_off", 16'h0000, in_reset);
		chk("clash", 16'h0000, hm.clash);
		results();
	end
endmodule : tb
`default_nettype wire
